/* File: src/acc_comparator_ctrl.sv */
// Operation
// - output status high when positive exceeds negative
// - synchronize raw result, one to two cycles
// - disable bit powers comparator down
// - bandgap select replaces positive pin input
// - matching edge sets flag regardless enable
// - irq needs flag, enable, global enable
// - vector acknowledge clears flag
// - writing one clears flag, zero ignored
// - capture enable routes output to timer
// - mode: toggle, reserved, falling, rising
// - mux enable, converter off: channel N
// - otherwise negative pin is used
// - mux lent only without power reduction
// - input disable gates pin buffer, reads zero
// - converter enable decides mux lending
//
// Implementation choices: strobed register access and the register offsets.
`default_nettype none
module acc_comparator_ctrl
    import acc_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // processor side
    input wire logic global_irq_en_in,
    input wire logic irq_vector_ack_in,
    output logic cmp_irq_out,
    output logic sys_irq_out,
    // comparator core
    input wire logic cmp_raw_in,
    output logic [6:0] analog_ctl_out,
    // pins' digital buffers
    input wire logic pos_pin_digital_in,
    input wire logic neg_pin_digital_in,
    output logic pos_pin_port_out,
    output logic neg_pin_port_out,
    output logic pos_pin_buffer_disable_out,
    output logic neg_pin_buffer_disable_out,
    // timer capture front end
    output logic capture_src_out,
    output logic capture_route_enable_out
);

    // control register state
    logic cmp_disable; // powers core off
    logic bandgap_select; // positive input source
    logic cmp_irq_flag; // sticky edge flag
    logic cmp_irq_enable; // interrupt enable
    logic capture_route_enable; // route to timer
    logic [1:0] irq_mode; // edge mode field
    logic neg_mux_enable; // borrow converter mux
    logic neg_pin_buffer_disable;
    logic pos_pin_buffer_disable;
    logic channel_select_hi;
    logic [2:0] channel_select_lo;
    logic converter_enable;
    logic converter_power_reduce;
    logic irq_mask; // system interrupt mask
    logic irq_status; // system sticky status
    // synchroniser and edge state
    // the raw result is asynchronous to our clock, so it is
    // caught by a first flop and settled by a second one; the
    // second flop is the readable output bit itself, which
    // keeps the delay from a raw change to the status bit at
    // one to two clocks depending on where the change falls
    // relative to the sampling edge
    logic cmp_sync1; // first stage, read by second only
    logic cmp_output_status; // second stage, readable output
    logic cmp_prev; // previous output for edges
    logic pos_sync1, pos_sync2, neg_sync1, neg_sync2;
    // note on the pin paths: each pin level is also asynchronous,
    // so it gets its own two-flop chain before the port gate
    // combinational helpers
    logic hit; // mode-matched edge
    logic wr_csr, wr_status;
    acc_neg_src_t neg_src;
    acc_analog_ctl_t next_analog;
    logic [7:0] next_rdata;

    // edge detector by mode; reserved mode never fires
    // cmp_prev and cmp_output_status both reset low, which is the
    // idle level of a powered-down core, so no false edge is
    // seen on the first clocks after reset
    // the mode field is read live, so a mode change can make a
    // pending level difference look like an event; software is
    // expected to mask the interrupt enable around such changes
    function automatic logic edge_match(input logic [1:0] mode,
                                        input logic prev,
                                        input logic cur);
        case (mode)
            MODE_TOGGLE: edge_match = prev ^ cur;
            MODE_FALL: edge_match = prev & ~cur;
            MODE_RISE: edge_match = ~prev & cur;
            default: edge_match = 1'b0;
        endcase
    endfunction : edge_match

    assign wr_csr = reg_wr_in && (reg_addr_in == ADDR_CMP_CSR);
    assign wr_status = reg_wr_in && (reg_addr_in == ADDR_IRQ_STATUS);
    // flag events come only from synchronized output transitions
    assign hit = edge_match(irq_mode, cmp_prev, cmp_output_status);

    // negative input source selection
    // the converter multiplexer may only be lent to the
    // comparator while the converter is off and not held in
    // power reduction; in every other case the dedicated
    // negative pin is used
    // the channel index is passed through unchanged; the core
    // only looks at it when the lent path is chosen
    always_comb begin
        if (neg_mux_enable && !converter_enable
            && !converter_power_reduce) begin
            neg_src = ACC_NEG_MUX;
        end else begin
            neg_src = ACC_NEG_PIN;
        end
        next_analog.power_down = cmp_disable;
        next_analog.pos_bandgap = bandgap_select;
        next_analog.neg_from_mux = (neg_src == ACC_NEG_MUX);
        next_analog.channel = {channel_select_hi, channel_select_lo};
    end

    // comparator csr writes; control bits reset to zero
    // the output bit is read-only and the flag is handled in its
    // own process, so neither is touched here
    // disabling the core is allowed at any time; the hazard of a
    // spurious event on power change is left to software
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmp_disable <= 1'b0;
            bandgap_select <= 1'b0;
            cmp_irq_enable <= 1'b0;
            capture_route_enable <= 1'b0;
            irq_mode <= MODE_TOGGLE;
        end else if (clk_en_in && wr_csr) begin
            cmp_disable <= reg_wdata_in[CSR_DISABLE];
            bandgap_select <= reg_wdata_in[CSR_BANDGAP];
            cmp_irq_enable <= reg_wdata_in[CSR_IRQ_EN];
            capture_route_enable <= reg_wdata_in[CSR_CAPTURE];
            irq_mode <= {reg_wdata_in[CSR_MODE_HI], reg_wdata_in[CSR_MODE_LO]};
        end
    end

    // other control registers
    // converter enable, power reduction and channel select are
    // local copies held here so the steering can be decided in
    // one place; writes to unmapped offsets are dropped
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            neg_mux_enable <= 1'b0;
            neg_pin_buffer_disable <= 1'b0;
            pos_pin_buffer_disable <= 1'b0;
            channel_select_hi <= 1'b0;
            channel_select_lo <= 3'h0;
            converter_enable <= 1'b0;
            converter_power_reduce <= 1'b0;
            irq_mask <= 1'b0;
        end else if (clk_en_in && reg_wr_in) begin
            case (reg_addr_in)
                ADDR_CONTROL_B: begin
                    neg_mux_enable <= reg_wdata_in[CTLB_MUX_EN];
                end
                ADDR_DIDR: begin
                    neg_pin_buffer_disable <= reg_wdata_in[DIDR_NEG];
                    pos_pin_buffer_disable <= reg_wdata_in[DIDR_POS];
                end
                ADDR_MUX_SEL: begin
                    channel_select_hi <= reg_wdata_in[MUXSEL_HI];
                    channel_select_lo <= reg_wdata_in[2:0];
                end
                ADDR_CONV_CTRL: begin
                    converter_enable <= reg_wdata_in[CONV_ENABLE];
                    converter_power_reduce <= reg_wdata_in[CONV_PWR_REDUCE];
                end
                ADDR_IRQ_MASK: begin
                    irq_mask <= reg_wdata_in[IRQ_EDGE];
                end
                default: begin
                end
            endcase
        end
    end

    // two-flop synchroniser for the raw comparator result
    // only the second flop reads the first; everything else,
    // the edge detector included, looks at the second flop
    // cmp_prev holds the previous settled value so that the
    // edge detector compares two clean samples
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmp_sync1 <= 1'b0;
            cmp_output_status <= 1'b0;
            cmp_prev <= 1'b0;
        end else if (clk_en_in) begin
            cmp_sync1 <= cmp_raw_in;
            cmp_output_status <= cmp_sync1;
            cmp_prev <= cmp_output_status;
        end
    end

    // pin digital inputs, synchronised
    // the buffer-disable gate is applied after the chain, so a
    // disabled pin reads zero from the next output update on
    // even if its synchroniser still holds an old high level
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pos_sync1 <= 1'b0;
            pos_sync2 <= 1'b0;
            neg_sync1 <= 1'b0;
            neg_sync2 <= 1'b0;
        end else if (clk_en_in) begin
            pos_sync1 <= pos_pin_digital_in;
            pos_sync2 <= pos_sync1;
            neg_sync1 <= neg_pin_digital_in;
            neg_sync2 <= neg_sync1;
        end
    end

    // comparator flag: set wins over both clears
    // an event that lands in the same clock as a vector
    // acknowledge or a write-one clear must not be lost, so the
    // set branch is tested first
    // writing zero to the flag position leaves it alone, which
    // lets software rewrite the other csr bits safely
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cmp_irq_flag <= 1'b0;
        end else if (clk_en_in) begin
            if (hit) begin
                cmp_irq_flag <= 1'b1;
            end else if (irq_vector_ack_in) begin
                cmp_irq_flag <= 1'b0;
            end else if (wr_csr && reg_wdata_in[CSR_FLAG]) begin
                cmp_irq_flag <= 1'b0;
            end
        end
    end

    // system sticky status, write one to clear, set wins
    // this copy of the event is independent of the comparator
    // enable and is only gated by its own mask at the output
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_status <= 1'b0;
        end else if (clk_en_in) begin
            if (hit) begin
                irq_status <= 1'b1;
            end else if (wr_status && reg_wdata_in[IRQ_EDGE]) begin
                irq_status <= 1'b0;
            end
        end
    end

    // read mux; unmapped reads zero
    // the mux is sampled into reg_rdata_out only when the read
    // strobe is high, so data stand for exactly one cycle after
    // the strobe and the bus shows zero otherwise
    always_comb begin
        next_rdata = RESET_BYTE;
        case (reg_addr_in)
            ADDR_CONTROL_B: next_rdata[CTLB_MUX_EN] = neg_mux_enable;
            ADDR_CMP_CSR: begin
                next_rdata[CSR_DISABLE] = cmp_disable;
                next_rdata[CSR_BANDGAP] = bandgap_select;
                next_rdata[CSR_OUTPUT] = cmp_output_status;
                next_rdata[CSR_FLAG] = cmp_irq_flag;
                next_rdata[CSR_IRQ_EN] = cmp_irq_enable;
                next_rdata[CSR_CAPTURE] = capture_route_enable;
                next_rdata[CSR_MODE_HI] = irq_mode[1];
                next_rdata[CSR_MODE_LO] = irq_mode[0];
            end
            ADDR_DIDR: begin
                next_rdata[DIDR_NEG] = neg_pin_buffer_disable;
                next_rdata[DIDR_POS] = pos_pin_buffer_disable;
            end
            ADDR_MUX_SEL: begin
                next_rdata[MUXSEL_HI] = channel_select_hi;
                next_rdata[2:0] = channel_select_lo;
            end
            ADDR_CONV_CTRL: begin
                next_rdata[CONV_ENABLE] = converter_enable;
                next_rdata[CONV_PWR_REDUCE] = converter_power_reduce;
            end
            ADDR_IRQ_STATUS: next_rdata[IRQ_EDGE] = irq_status;
            ADDR_IRQ_MASK: next_rdata[IRQ_EDGE] = irq_mask;
            default: next_rdata = RESET_BYTE;
        endcase
    end

    // registered outputs
    // every top-level output comes from this flop bank, so the
    // interrupt lines, the steering and the pin ports all lag
    // their sources by one clock
    // the comparator interrupt is a level: it drops one clock
    // after the flag, the enable or the global enable drops
    // the capture path forwards the settled result only; the
    // timer's own noise canceller and edge select follow it
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            reg_rdata_out <= RESET_BYTE;
            cmp_irq_out <= 1'b0;
            sys_irq_out <= 1'b0;
            analog_ctl_out <= 7'h00;
            pos_pin_port_out <= 1'b0;
            neg_pin_port_out <= 1'b0;
            pos_pin_buffer_disable_out <= 1'b0;
            neg_pin_buffer_disable_out <= 1'b0;
            capture_src_out <= 1'b0;
            capture_route_enable_out <= 1'b0;
        end else if (clk_en_in) begin
            reg_rdata_out <= reg_rd_in ? next_rdata : RESET_BYTE;
            // the enable guard is software's duty when changing mode/power
            cmp_irq_out <= cmp_irq_flag && cmp_irq_enable
                           && global_irq_en_in;
            sys_irq_out <= irq_status && irq_mask;
            analog_ctl_out <= next_analog;
            pos_pin_port_out <= pos_sync2 && !pos_pin_buffer_disable;
            neg_pin_port_out <= neg_sync2 && !neg_pin_buffer_disable;
            pos_pin_buffer_disable_out <= pos_pin_buffer_disable;
            neg_pin_buffer_disable_out <= neg_pin_buffer_disable;
            // timer side needs its own capture interrupt enable
            capture_src_out <= capture_route_enable
                               && cmp_output_status;
            capture_route_enable_out <= capture_route_enable;
        end
    end

endmodule : acc_comparator_ctrl
`default_nettype wire

/* File: src/acc_pkg.sv */
`default_nettype none
package acc_pkg;
    // register offsets (byte addresses on the plain register port)
    localparam logic [3:0] ADDR_CONTROL_B = 4'h0;
    localparam logic [3:0] ADDR_CMP_CSR = 4'h1;
    localparam logic [3:0] ADDR_DIDR = 4'h2;
    localparam logic [3:0] ADDR_MUX_SEL = 4'h3;
    localparam logic [3:0] ADDR_CONV_CTRL = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h5;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;

    // comparator control/status bit positions
    localparam int CSR_DISABLE = 7;
    localparam int CSR_BANDGAP = 6;
    localparam int CSR_OUTPUT = 5;
    localparam int CSR_FLAG = 4;
    localparam int CSR_IRQ_EN = 3;
    localparam int CSR_CAPTURE = 2;
    localparam int CSR_MODE_HI = 1;
    localparam int CSR_MODE_LO = 0;

    // other bit positions
    localparam int CTLB_MUX_EN = 6;
    localparam int DIDR_NEG = 1;
    localparam int DIDR_POS = 0;
    localparam int MUXSEL_HI = 5;
    localparam int CONV_ENABLE = 7;
    localparam int CONV_PWR_REDUCE = 0;
    localparam int IRQ_EDGE = 0;

    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // interrupt mode encodings
    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_RISE = 2'h3;

    // negative source select
    typedef enum logic [1:0] {
        ACC_NEG_PIN = 2'b01,
        ACC_NEG_MUX = 2'b10
    } acc_neg_src_t;

    // analog steering bundle sent to the comparator core
    typedef struct packed {
        logic power_down;
        logic pos_bandgap;
        logic neg_from_mux;
        logic [3:0] channel;
    } acc_analog_ctl_t;
endpackage : acc_pkg
`default_nettype wire

/* File: tb/acc_analog_model.sv */
`default_nettype none
module acc_analog_model
    import acc_pkg::*;
#(
    parameter int BANDGAP_MV = 100, // nominal reference level
    parameter int STEP_MV = 20 // channel n sits at n steps
)(
    // steering from the block
    input wire logic [6:0] analog_ctl_in,
    // pin levels in millivolts
    input wire logic [15:0] pos_mv_in,
    input wire logic [15:0] neg_mv_in,
    // raw comparator result
    output logic cmp_raw_out
);
    timeunit 1ns;
    timeprecision 1ns;
    acc_analog_ctl_t ctl; // decoded steering
    logic [15:0] pos_mv; // chosen positive level
    logic [15:0] neg_mv; // chosen negative level
    assign ctl = analog_ctl_in;
    // positive input: bandgap or pin
    assign pos_mv = ctl.pos_bandgap ? 16'(BANDGAP_MV) : pos_mv_in;
    // negative input: lent channel or pin
    assign neg_mv = ctl.neg_from_mux ? 16'(STEP_MV * ctl.channel)
                                     : neg_mv_in;
    // a powered-down core idles low
    assign cmp_raw_out = !ctl.power_down && pos_mv > neg_mv;
endmodule : acc_analog_model
`default_nettype wire

/* File: tb/acc_ctrl_monitor.sv */
`default_nettype none
module acc_ctrl_monitor
    import acc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    // inputs watched
    input wire logic clk_en_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic global_irq_en_in,
    input wire logic irq_vector_ack_in,
    input wire logic cmp_raw_in,
    // outputs watched
    input wire logic cmp_irq_out,
    input wire logic [6:0] analog_ctl_out,
    input wire logic pos_pin_port_out,
    input wire logic pos_pin_buffer_disable_out,
    input wire logic capture_src_out,
    input wire logic capture_route_enable_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    // a write to the comparator csr is taken
    logic csr_wr;
    assign csr_wr = clk_en_in && reg_wr_in && reg_addr_in == ADDR_CMP_CSR;
    // disable bit lands on the power-down line
    property p_pwr;
        csr_wr ##1 !csr_wr |->
            ##1 analog_ctl_out[6] == $past(reg_wdata_in[CSR_DISABLE], 2);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power down wrong");
    // bandgap bit lands on the positive select line
    property p_bg;
        csr_wr ##1 !csr_wr |->
            ##1 analog_ctl_out[5] == $past(reg_wdata_in[CSR_BANDGAP], 2);
    endproperty
    a_bg: assert property (p_bg) else $error("bandgap select wrong");
    // a request never rises without the global enable
    property p_gie;
        $rose(cmp_irq_out) |-> $past(global_irq_en_in);
    endproperty
    a_gie: assert property (p_gie) else $error("irq without global");
    // vector acknowledge drops the request with no event pending
    property p_ack;
        $stable(cmp_raw_in)[*5] ##0 irq_vector_ack_in |-> ##[1:2] !cmp_irq_out;
    endproperty
    a_ack: assert property (p_ack) else $error("ack kept irq");
    // writing one to the flag drops the request
    property p_w1c;
        $stable(cmp_raw_in)[*5] ##0 (csr_wr && reg_wdata_in[CSR_FLAG]) |->
            ##[1:2] !cmp_irq_out;
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");
    // routed output follows a steady high result
    property p_cap;
        (cmp_raw_in && capture_route_enable_out)[*6] |-> capture_src_out;
    endproperty
    a_cap: assert property (p_cap) else $error("capture not routed");
    // disabled buffer reads zero
    property p_pin;
        pos_pin_buffer_disable_out[*2] |-> !pos_pin_port_out;
    endproperty
    a_pin: assert property (p_pin) else $error("pin not gated");
    // steering and comparator request idle at the first edge after reset
    property p_rst;
        $rose(rst_b_in) |-> analog_ctl_out == 7'h00 && !cmp_irq_out;
    endproperty
    a_rst: assert property (p_rst) else $error("reset value wrong");
endmodule : acc_ctrl_monitor
bind acc_comparator_ctrl acc_ctrl_monitor u_mon (.ref_clk_in, .rst_b_in,
    .clk_en_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .global_irq_en_in,
    .irq_vector_ack_in, .cmp_raw_in, .cmp_irq_out, .analog_ctl_out,
    .pos_pin_port_out, .pos_pin_buffer_disable_out, .capture_src_out,
    .capture_route_enable_out);
`default_nettype wire

/* File: tb/tb_top.sv */
`default_nettype none
module tb_top
    import acc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in, rst_b_in, clk_en_in, reg_wr_in, reg_rd_in;
    logic global_irq_en_in, irq_vector_ack_in, cmp_irq_out, sys_irq_out;
    logic cmp_raw_in, pos_pin_digital_in, neg_pin_digital_in;
    logic pos_pin_port_out, neg_pin_port_out, capture_src_out;
    logic pos_pin_buffer_disable_out, neg_pin_buffer_disable_out;
    logic capture_route_enable_out;
    logic [3:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out;
    logic [6:0] analog_ctl_out;
    logic [15:0] pv, nv; // pin levels in millivolts
    int failures, n_compared, cycles;
    acc_comparator_ctrl dut (.ref_clk_in, .rst_b_in, .clk_en_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .global_irq_en_in, .irq_vector_ack_in, .cmp_irq_out, .sys_irq_out,
        .cmp_raw_in, .analog_ctl_out, .pos_pin_digital_in, .neg_pin_digital_in,
        .pos_pin_port_out, .neg_pin_port_out, .pos_pin_buffer_disable_out,
        .neg_pin_buffer_disable_out, .capture_src_out, .capture_route_enable_out);
    acc_analog_model u_core (.analog_ctl_in(analog_ctl_out), .pos_mv_in(pv),
        .neg_mv_in(nv), .cmp_raw_out(cmp_raw_in));
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // hang guard
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask : w
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    // read, mask and compare; data stand one cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [7:0] m, e,
                        input string nm);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        chk(nm, e, reg_rdata_out & m);
    endtask : rchk
    task automatic test_reset;
        wr(4'hF, 8'hFF); // stray write to an unmapped place
        for (int a = 0; a < 7; a++) begin
            rchk(4'(a), 8'hFF, 8'h00, "reset value");
        end
        rchk(4'hF, 8'hFF, 8'h00, "unmapped read");
        $display("test reset done");
    endtask : test_reset
    task automatic test_select;
        @(posedge ref_clk_in) {pv, nv} <= {16'h0032, 16'h003C};
        wr(ADDR_CMP_CSR, 8'h40);
        w(6);
        rchk(ADDR_CMP_CSR, 8'h20, 8'h20, "bandgap output");
        wr(ADDR_CONTROL_B, 8'h40);
        wr(ADDR_MUX_SEL, 8'h21);
        w(6);
        chk("steering", 8'h39, 8'(analog_ctl_out));
        rchk(ADDR_CMP_CSR, 8'h20, 8'h00, "channel output");
        wr(ADDR_CONV_CTRL, 8'h80);
        w(6);
        chk("converter on", 8'h02, 8'(analog_ctl_out[6:4]));
        rchk(ADDR_CMP_CSR, 8'h20, 8'h20, "pin output");
        wr(ADDR_CONV_CTRL, 8'h01);
        w(6);
        chk("power reduced", 8'h02, 8'(analog_ctl_out[6:4]));
        wr(ADDR_CMP_CSR, 8'hC0);
        w(6);
        chk("powered down", 8'h06, 8'(analog_ctl_out[6:4]));
        rchk(ADDR_CMP_CSR, 8'h20, 8'h00, "off output");
        wr(ADDR_CMP_CSR, 8'h00);
        wr(ADDR_CONTROL_B, 8'h00);
        wr(ADDR_CONV_CTRL, 8'h00);
        $display("test select done");
    endtask : test_select
    task automatic test_modes;
        logic f;
        @(posedge ref_clk_in) global_irq_en_in <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_CMP_CSR, 8'(m));
            wr(ADDR_CMP_CSR, 8'h18 | 8'(m));
            @(posedge ref_clk_in) pv <= 16'h0046;
            w(6);
            f = m == 0 || m == 3;
            rchk(ADDR_CMP_CSR, 8'h10, {3'b000, f, 4'h0}, "rise flag");
            chk("irq request", 8'(f), 8'(cmp_irq_out));
            wr(ADDR_CMP_CSR, 8'h08 | 8'(m));
            rchk(ADDR_CMP_CSR, 8'h10, {3'b000, f, 4'h0}, "kept flag");
            @(posedge ref_clk_in) pv <= 16'h0032;
            w(6);
            f = f || m == 0 || m == 2;
            rchk(ADDR_CMP_CSR, 8'h10, {3'b000, f, 4'h0}, "fall flag");
            wr(ADDR_CMP_CSR, 8'h10 | 8'(m));
            rchk(ADDR_CMP_CSR, 8'h10, 8'h00, "cleared flag");
        end
        $display("test modes done");
    endtask : test_modes
    task automatic test_irq;
        wr(ADDR_CMP_CSR, 8'h13);
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_IRQ_STATUS, 8'h01);
        @(posedge ref_clk_in) pv <= 16'h0046;
        w(6);
        rchk(ADDR_CMP_CSR, 8'h10, 8'h10, "flag");
        chk("disabled irq", 8'h00, 8'(cmp_irq_out));
        rchk(ADDR_IRQ_STATUS, 8'h01, 8'h01, "status");
        chk("masked", 8'h00, 8'(sys_irq_out));
        wr(ADDR_IRQ_MASK, 8'h01);
        w(2);
        chk("unmasked", 8'h01, 8'(sys_irq_out));
        wr(ADDR_IRQ_STATUS, 8'h01);
        w(2);
        chk("status cleared", 8'h00, 8'(sys_irq_out));
        @(posedge ref_clk_in) global_irq_en_in <= 1'b0;
        wr(ADDR_CMP_CSR, 8'h0B);
        w(2);
        chk("global off", 8'h00, 8'(cmp_irq_out));
        @(posedge ref_clk_in) global_irq_en_in <= 1'b1;
        w(2);
        chk("global on", 8'h01, 8'(cmp_irq_out));
        @(posedge ref_clk_in) irq_vector_ack_in <= 1'b1;
        @(posedge ref_clk_in) irq_vector_ack_in <= 1'b0;
        w(2);
        chk("acked", 8'h00, 8'(cmp_irq_out));
        rchk(ADDR_CMP_CSR, 8'h10, 8'h00, "acked flag");
        wr(ADDR_CMP_CSR, 8'h00);
        $display("test irq done");
    endtask : test_irq
    task automatic test_pins;
        @(posedge ref_clk_in) {pos_pin_digital_in, neg_pin_digital_in} <= 2'b11;
        wr(ADDR_DIDR, 8'h03);
        w(4);
        chk("pins off", 8'h03, 8'({pos_pin_port_out, neg_pin_port_out,
            pos_pin_buffer_disable_out, neg_pin_buffer_disable_out}));
        wr(ADDR_DIDR, 8'h00);
        w(4);
        chk("pins on", 8'h0C, 8'({pos_pin_port_out, neg_pin_port_out,
            pos_pin_buffer_disable_out, neg_pin_buffer_disable_out}));
        wr(ADDR_CMP_CSR, 8'h04);
        w(6);
        chk("capture", 8'h03,
            8'({capture_route_enable_out, capture_src_out}));
        wr(ADDR_CMP_CSR, 8'h00);
        w(2);
        chk("no capture", 8'h00,
            8'({capture_route_enable_out, capture_src_out}));
        $display("test pins done");
    endtask : test_pins
    initial begin
        {rst_b_in, reg_wr_in, reg_rd_in, global_irq_en_in} = '0;
        {irq_vector_ack_in, pos_pin_digital_in, neg_pin_digital_in} = '0;
        {reg_addr_in, reg_wdata_in, pv, nv} = '0;
        clk_en_in = 1'b1;
        repeat (4) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        test_reset();
        test_select();
        test_modes();
        test_irq();
        test_pins();
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
